/* File: hw/cdc_result_pkg.sv */
// Constants for the converter's result and status register bank, read-only except for the interrupt mask.
// Assumes a 32-bit AHB-Lite register bus, each register one aligned word.
package cdc_result_pkg;

	// Result word format: unsigned fixed point, integer and fractional bits
	localparam int RESULT_WORDS      = 8;
	localparam int RESULT_WIDTH      = 32;
	localparam int RESULT_INT_BITS   = 5;
	localparam int RESULT_FRAC_BITS  = 27;
	localparam int RESULT_IDX_WIDTH  = 3;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

	// Register indices; the byte address is four times the index
	localparam int INDEX_WIDTH           = 6;
	localparam logic [5:0] IDX_RESULT_LO = 6'h00;
	localparam logic [5:0] IDX_RESULT_HI = 6'h1f;
	localparam logic [5:0] IDX_FIRST_STATUS = 6'h20;
	localparam logic [5:0] IDX_ERROR_STATUS = 6'h21;
	localparam logic [5:0] IDX_PORT_ERROR   = 6'h22;
	localparam logic [5:0] IDX_IRQ_STATUS   = 6'h28;
	localparam logic [5:0] IDX_IRQ_MASK     = 6'h29;

	// First status byte fields
	localparam int FS_WDOG_POR  = 7;
	localparam int FS_CFG_POR   = 6;
	localparam int FS_COLLISION = 5;
	localparam int FS_AUTOBOOT  = 4;
	localparam int FS_RES_READY = 2;
	localparam int FS_CAP_ACT   = 1;
	localparam int FS_RUN       = 0;

	// Error status byte fields
	localparam int ES_RES_ERR  = 3;
	localparam int ES_TDC_ERR  = 2;
	localparam int ES_OVFL_ERR = 1;
	localparam int ES_COMB_ERR = 0;

	// Port error byte: ports 0..5 and the internal reference in bit 6
	localparam int PORT_FLAGS   = 7;
	localparam int PE_INT_REF   = 6;

	// Interrupt status and mask fields
	localparam int IRQ_BITS      = 8;
	localparam int IRQ_WDOG      = 0;
	localparam int IRQ_CFG       = 1;
	localparam int IRQ_COLLISION = 2;
	localparam int IRQ_RES_ERR   = 3;
	localparam int IRQ_TDC_ERR   = 4;
	localparam int IRQ_OVFL_ERR  = 5;
	localparam int IRQ_PORT_ERR  = 6;
	localparam int IRQ_RESULT    = 7;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

endpackage : cdc_result_pkg

/* File: hw/cdc_result_status_regs.sv */
// Result and status register bank of the capacitance converter, AHB-Lite slave.
// Assumes the firmware side writes result words and reports events synchronously
// to i_clock; all inputs are synchronous; one clock, asynchronous reset.
//
// The AHB-Lite register port was chosen for this implementation.

// Address map, byte address = 4 * index, one byte of data per index:
//   0x00..0x7c  result words 0..7, four indices each, least significant first
//   0x80        first status byte
//   0x84        error status byte
//   0x88        port error byte
//   0xa0        interrupt status, cleared by its read
//   0xa4        interrupt mask, the only writable register
// Reads of any other index return zero with an OKAY answer.

module cdc_result_status_regs
	import cdc_result_pkg::*;
(
	// Clock and reset
	input  wire logic                           i_clock,
	input  wire logic                           i_rst,
	// AHB-Lite slave
	input  wire logic                           i_hsel,
	input  wire logic [31:0]                    i_haddr,
	input  wire logic [1:0]                     i_htrans,
	input  wire logic                           i_hwrite,
	input  wire logic [2:0]                     i_hsize,
	input  wire logic [31:0]                    i_hwdata,
	input  wire logic                           i_hready,
	output logic      [31:0]                    o_hrdata,
	output logic                                o_hreadyout,
	output logic                                o_hresp,
	// Firmware result write port
	input  wire logic                           i_result_wr,
	input  wire logic [cdc_result_pkg::RESULT_IDX_WIDTH-1:0] i_result_idx,
	input  wire logic [cdc_result_pkg::RESULT_WIDTH-1:0]     i_result_data,
	// Reset causes and trigger collision
	input  wire logic                           i_wdog_por,
	input  wire logic                           i_config_por,
	input  wire logic                           i_cause_clear,
	input  wire logic                           i_cap_trigger,
	input  wire logic                           i_dsp_active,
	output logic                                o_initial_reset,
	// Converter state
	input  wire logic                           i_autoboot_busy,
	input  wire logic                           i_res_conv_ready,
	input  wire logic                           i_res_conv_busy,
	input  wire logic                           i_cap_conv_active,
	input  wire logic                           i_run_enable,
	// Converter error events
	input  wire logic                           i_conv_start,
	input  wire logic                           i_res_conv_error,
	input  wire logic                           i_tdc_error,
	input  wire logic                           i_overflow_error,
	input  wire logic [cdc_result_pkg::PORT_FLAGS-1:0] i_cap_port_fault,
	// Interrupt
	output logic                                o_irq
);

	typedef struct packed {
		// Result words as the firmware stored them
		logic [RESULT_WORDS-1:0][RESULT_WIDTH-1:0] result;
		// Reset causes and trigger collision
		logic                    wdog_por;
		logic                    cfg_por;
		logic                    trigger_collision_flag;
		// Converter error flags
		logic                    resistance_conv_error;
		logic                    tdc_error;
		logic                    overflow_error;
		logic [PORT_FLAGS-1:0]   cap_port_fault;
		// Interrupt status and mask
		logic [IRQ_BITS-1:0]     irq_status;
		logic [IRQ_BITS-1:0]     irq_mask;
		// Write waiting for its data phase
		logic                    wr_pending;
		logic [INDEX_WIDTH-1:0]  wr_index;
		// Registered outputs
		logic [31:0]             hrdata;
		logic                    hreadyout;
		logic                    hresp;
		logic                    irq;
		logic                    initial_reset;
	} state_type;

	state_type s_r;
	state_type s_nxt;

	logic [7:0]             first_status;
	logic [7:0]             error_status;
	logic [7:0]             port_error;
	logic [INDEX_WIDTH-1:0] addr_index;
	logic                   addr_phase;
	logic [IRQ_BITS-1:0]    irq_events;
	logic [31:0]            read_word;

	assign addr_index = i_haddr[INDEX_WIDTH+1:2];
	assign addr_phase = i_hsel & i_htrans[1] & i_hready;

	// Decoded selects. The result bank fills the low indices, one byte per index,
	// so a word is read as four transfers; the host must read all four lanes of a
	// word before firmware rewrites it, or it may see a mix of two values.
	logic                        rd_take;
	logic                        wr_take;
	logic                        sel_result;
	logic                        sel_first;
	logic                        sel_error;
	logic                        sel_port;
	logic                        sel_irq_status;
	logic                        sel_irq_mask;
	logic [RESULT_IDX_WIDTH-1:0] word_sel;
	logic [1:0]                  byte_sel;
	logic [RESULT_WORDS-1:0][3:0][7:0] result_bytes;
	logic [7:0]                  result_byte;
	logic [PORT_FLAGS-1:0]       port_fault_hit;

	// A transfer counts only while the bus is ready
	assign rd_take = addr_phase & ~i_hwrite;
	assign wr_take = addr_phase & i_hwrite;

	// One select per register; at most one is high
	assign sel_result     = (addr_index <= IDX_RESULT_HI);
	assign sel_first      = (addr_index == IDX_FIRST_STATUS);
	assign sel_error      = (addr_index == IDX_ERROR_STATUS);
	assign sel_port       = (addr_index == IDX_PORT_ERROR);
	assign sel_irq_status = (addr_index == IDX_IRQ_STATUS);
	assign sel_irq_mask   = (addr_index == IDX_IRQ_MASK);
	assign word_sel       = addr_index[4:2];
	assign byte_sel       = addr_index[1:0];

	// Byte lanes of each stored word, least significant lane first
	for (genvar w = 0; w < RESULT_WORDS; w++) begin : g_word
		for (genvar b = 0; b < 4; b++) begin : g_lane
			assign result_bytes[w][b] = s_r.result[w][8*b +: 8];
		end
	end

	assign result_byte = result_bytes[word_sel][byte_sel];

	// Each port is qualified on its own, so one faulty port marks only itself;
	// a fault seen while the converter is idle is ignored as noise
	for (genvar p = 0; p < PORT_FLAGS; p++) begin : g_port
		assign port_fault_hit[p] = i_cap_port_fault[p] & i_cap_conv_active;
	end

	// Qualified events: an error counts only while its converter is busy
	logic                        collision;
	logic                        res_err_hit;
	logic                        tdc_err_hit;
	logic                        ovfl_err_hit;

	assign collision    = i_cap_trigger & i_dsp_active;
	assign res_err_hit  = i_res_conv_error & i_res_conv_busy;
	assign tdc_err_hit  = i_tdc_error & i_cap_conv_active;
	assign ovfl_err_hit = i_overflow_error & i_cap_conv_active;

	// Combined error is formed live from the held flags, never stored, so it
	// can never disagree with the bits it summarises
	logic                        any_error;

	always_comb begin
		any_error = s_r.resistance_conv_error;
		any_error = any_error | s_r.tdc_error;
		any_error = any_error | s_r.overflow_error;
		any_error = any_error | (|s_r.cap_port_fault);
	end

	// Status bytes as the host sees them. Converter levels are shown live, so a
	// read reports the level in its own address phase; the held flags only change
	// on their own set and clear inputs. Bits with no function read as zero.
	always_comb begin
		// Reset causes, collision and live converter levels
		first_status               = 8'h00;
		first_status[FS_WDOG_POR]  = s_r.wdog_por;
		first_status[FS_CFG_POR]   = s_r.cfg_por;
		first_status[FS_COLLISION] = s_r.trigger_collision_flag;
		first_status[FS_AUTOBOOT]  = i_autoboot_busy;
		first_status[FS_RES_READY] = i_res_conv_ready;
		first_status[FS_CAP_ACT]   = i_cap_conv_active;
		first_status[FS_RUN]       = i_run_enable;

		// Latched converter errors and their combination
		error_status               = 8'h00;
		error_status[ES_RES_ERR]   = s_r.resistance_conv_error;
		error_status[ES_TDC_ERR]   = s_r.tdc_error;
		error_status[ES_OVFL_ERR]  = s_r.overflow_error;
		error_status[ES_COMB_ERR]  = any_error;

		// One fault flag per port, internal reference in the top used bit
		port_error                 = {1'b0, s_r.cap_port_fault};
	end

	// Read mux: one byte per index for the bank, narrow data in the low bits.
	// Indices with no register read zero and still answer OKAY, so a host that
	// scans the whole space sees no error.
	always_comb begin
		read_word = 32'h0000_0000;
		if (sel_result) begin
			// Least significant byte at the lowest index
			read_word[7:0] = result_byte;
		end else if (sel_first) begin
			read_word[7:0] = first_status;
		end else if (sel_error) begin
			read_word[7:0] = error_status;
		end else if (sel_port) begin
			read_word[7:0] = port_error;
		end else if (sel_irq_status) begin
			// Interrupt registers sit after the status bytes
			read_word[IRQ_BITS-1:0] = s_r.irq_status;
		end else if (sel_irq_mask) begin
			read_word[IRQ_BITS-1:0] = s_r.irq_mask;
		end
	end

	// Events that raise interrupt status bits. Each bit uses the same qualifier
	// as the status flag it mirrors, so an interrupt never points at a flag that
	// stayed clear. The result bit fires on every firmware store, not only when
	// a whole set of words is complete.
	always_comb begin
		irq_events                = '0;
		// Reset causes and the trigger collision
		irq_events[IRQ_WDOG]      = i_wdog_por;
		irq_events[IRQ_CFG]       = i_config_por;
		irq_events[IRQ_COLLISION] = collision;
		// Converter errors, qualified by the busy converter
		irq_events[IRQ_RES_ERR]   = res_err_hit;
		irq_events[IRQ_TDC_ERR]   = tdc_err_hit;
		irq_events[IRQ_OVFL_ERR]  = ovfl_err_hit;
		irq_events[IRQ_PORT_ERR]  = |port_fault_hit;
		// New firmware result
		irq_events[IRQ_RESULT]    = i_result_wr;
	end

	// Next state of the whole bank. Every section starts from the held value, so
	// a field that no section touches keeps its content. Order matters: clears
	// come before sets in each section, which makes a set in the same cycle win.
	// The bus answer fields are forced every cycle: the slave never inserts wait
	// states and never answers with an error. The initial reset request is a
	// single-cycle pulse, so it is dropped here and raised again only by a new
	// collision.
	always_comb begin
		s_nxt               = s_r;
		s_nxt.hreadyout     = 1'b1;
		s_nxt.hresp         = 1'b0;
		s_nxt.initial_reset = 1'b0;

		// Firmware alone decides the word contents; the bank stores them as given.
		// No ratio is checked or zeroed here: which word holds which ratio, and
		// whether unused words read zero, is up to the running firmware. A store
		// and a host read of the same word in one cycle return the old value.
		if (i_result_wr) begin
			s_nxt.result[i_result_idx] = i_result_data;
		end

		// Reset cause flags; a new cause wins over the clear.
		// These survive bus traffic: only the firmware's clear input drops them,
		// so the host can still read the cause after the device has restarted.
		// A cause and the clear in one cycle leave the cause set.
		if (i_cause_clear) begin
			s_nxt.wdog_por               = 1'b0;
			s_nxt.cfg_por                = 1'b0;
			s_nxt.trigger_collision_flag = 1'b0;
		end
		if (i_wdog_por) begin
			s_nxt.wdog_por = 1'b1;
		end
		if (i_config_por) begin
			s_nxt.cfg_por = 1'b1;
		end
		if (i_cap_trigger && i_dsp_active) begin
			s_nxt.trigger_collision_flag = 1'b1;
			s_nxt.initial_reset          = 1'b1;
		end

		// Error flags restart with each conversion; a fresh error wins.
		// A start and an error in one cycle leave the error set, since the error
		// belongs to the conversion that is just beginning. Errors outside a busy
		// converter are not latched at all.
		if (i_conv_start) begin
			s_nxt.resistance_conv_error = 1'b0;
			s_nxt.tdc_error             = 1'b0;
			s_nxt.overflow_error        = 1'b0;
			s_nxt.cap_port_fault        = '0;
		end
		if (i_res_conv_error && i_res_conv_busy) begin
			s_nxt.resistance_conv_error = 1'b1;
		end
		if (i_tdc_error && i_cap_conv_active) begin
			s_nxt.tdc_error = 1'b1;
		end
		if (i_overflow_error && i_cap_conv_active) begin
			s_nxt.overflow_error = 1'b1;
		end
		// Port flags accumulate over the conversion, one bit per port
		s_nxt.cap_port_fault = s_nxt.cap_port_fault | port_fault_hit;

		// Bus address phase: reads answer in the next cycle.
		// Read data is captured here, in the address phase, so the host sees the
		// value at the moment of its request even if a flag changes in the data
		// phase. Write data only arrives in the next cycle, so a write is
		// remembered and applied then.
		s_nxt.wr_pending = 1'b0;
		s_nxt.hrdata     = 32'h0000_0000;
		if (wr_take) begin
			s_nxt.wr_pending = 1'b1;
			s_nxt.wr_index   = addr_index;
		end
		if (rd_take) begin
			s_nxt.hrdata = read_word;
		end

		// A read of the status clears it in its address phase; an event of the
		// same cycle is added afterwards and stays set, so nothing is lost
		// between the read and the clear.
		if (rd_take && sel_irq_status) begin
			s_nxt.irq_status = '0;
		end
		s_nxt.irq_status = s_nxt.irq_status | irq_events;

		// Bus data phase: only the mask takes a write; result and status ignore it.
		// The write is applied even if a new address phase overlaps it, as the
		// two never touch the same field. Upper data bits are dropped.
		if (s_r.wr_pending && s_r.wr_index == IDX_IRQ_MASK) begin
			s_nxt.irq_mask = i_hwdata[IRQ_BITS-1:0];
		end

		// The interrupt follows the next status and mask, so it rises in the
		// same cycle as the flag it reports, drops with the clearing read, and
		// follows a mask change at once.
		s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
	end

	// Every register takes its next value on each edge. Reset loads constants
	// only; the bus answer flop comes up ready so the first transfer after the
	// release is accepted without a wait.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s_r                        <= '0;
			s_r.result                 <= {RESULT_WORDS{RESULT_RESET}};
			// Mask comes up closed so nothing interrupts before software opens it
			s_r.irq_mask               <= IRQ_MASK_RESET;
			s_r.hreadyout              <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state flops, with no logic after them,
	// so they settle right after the clock edge
	assign o_hrdata        = s_r.hrdata;
	assign o_hreadyout     = s_r.hreadyout;
	assign o_hresp         = s_r.hresp;
	assign o_irq           = s_r.irq;
	assign o_initial_reset = s_r.initial_reset;

endmodule : cdc_result_status_regs

/* File: verification/cdc_result_status_chk.sv */
// Checker for the result and status bank: bus answers and status read relations.
// Assumes it is bound to cdc_result_status_regs and sees only its ports.
module cdc_result_status_chk (
	input wire logic        i_clock, i_rst, i_hsel, i_hwrite, i_hready,
	input wire logic [31:0] i_haddr, o_hrdata,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_cap_trigger, i_dsp_active, i_run_enable, i_cap_conv_active,
	input wire logic        o_hreadyout, o_hresp, o_initial_reset
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_any_rd;
		i_hsel && i_htrans[1] && i_hready && !i_hwrite;
	endsequence
	sequence s_rd(logic [31:0] a);
		s_any_rd ##0 (i_haddr == a);
	endsequence
	chk_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready or not okay");
	chk_rd_idle: assert property (!(i_hsel && i_htrans[1] && i_hready && !i_hwrite)
		|=> o_hrdata == 32'h0) else $error("read data outside data phase");
	chk_result_byte: assert property (s_any_rd ##0 (i_haddr < 32'h80)
		|=> o_hrdata[31:8] == 24'h0) else $error("result byte upper bits set");
	chk_status_mirror: assert property (s_rd(32'h80) |=> o_hrdata[31:8] == 24'h0
		&& !o_hrdata[3] && o_hrdata[1:0] == {$past(i_cap_conv_active), $past(i_run_enable)})
		else $error("first status byte wrong");
	chk_comb_error: assert property (s_rd(32'h84) |=> o_hrdata[31:4] == 28'h0
		&& (o_hrdata[0] || o_hrdata[3:1] == 3'h0)) else $error("combined error bit wrong");
	chk_port_byte: assert property (s_rd(32'h88) |=> o_hrdata[31:7] == 25'h0)
		else $error("port error byte upper bits set");
	chk_unmapped_zero: assert property (s_rd(32'hfc) |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_collision_pulse: assert property (i_cap_trigger && i_dsp_active |=> o_initial_reset)
		else $error("collision gave no initial reset");
	chk_no_collision: assert property (!(i_cap_trigger && i_dsp_active) |=> !o_initial_reset)
		else $error("initial reset without collision");
endmodule : cdc_result_status_chk

bind cdc_result_status_regs cdc_result_status_chk u_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_hsel(i_hsel), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_haddr(i_haddr),
	.o_hrdata(o_hrdata), .i_htrans(i_htrans), .i_cap_trigger(i_cap_trigger),
	.i_dsp_active(i_dsp_active), .i_run_enable(i_run_enable),
	.i_cap_conv_active(i_cap_conv_active), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_initial_reset(o_initial_reset));

/* File: verification/fw_model.sv */
// Firmware and converter side model: result writes, status levels and event pulses.
// Assumes the caller enters its tasks after a rising edge of i_clock.
module fw_model (
	input  wire logic        i_clock,
	output logic             o_result_wr,
	output logic [2:0]       o_result_idx,
	output logic [31:0]      o_result_data,
	output logic [20:0]      o_ev
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_result_wr = 1'b0;
		o_result_idx = 3'h0;
		o_result_data = 32'h0;
		o_ev = 21'h0;
	end
	// Any word may hold any pattern the firmware chooses
	task automatic put_result(input logic [2:0] k, input logic [31:0] v);
		@(posedge i_clock);
		o_result_wr <= 1'b1;
		o_result_idx <= k;
		o_result_data <= v;
		@(posedge i_clock);
		o_result_wr <= 1'b0;
		o_result_data <= ~v;
	endtask : put_result
	task automatic step(input logic [20:0] v);
		@(posedge i_clock);
		o_ev <= v;
	endtask : step
endmodule : fw_model

/* File: verification/tb_top.sv */
// Testbench for the result and status bank: AHB-Lite master tasks and checks.
// Assumes fw_model drives the firmware side and the checker is bound.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [20:0] LV = 21'h360, WDOG = 21'h1, CFG = 21'h2, CLR = 21'h4;
	localparam logic [20:0] TRIG = 21'h8, DSP = 21'h10, RBUSY = 21'h80, CAPA = 21'h100;
	localparam logic [20:0] CSTART = 21'h400, RERR = 21'h800, TDC = 21'h1000, OVF = 21'h2000;
	localparam logic [20:0] PF_ALL = 21'h1fc000, PF_REF = 21'h100000;
	logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, d, v;
	wire logic [31:0] hrdata, result_data;
	wire logic        hreadyout, hresp, irq, init_rst, result_wr;
	wire logic [2:0]  result_idx;
	wire logic [20:0] ev;
	int n_mismatch = 0, num_checks = 0;
	initial forever #4 clock = ~clock;
	fw_model fw (.i_clock(clock), .o_result_wr(result_wr), .o_result_idx(result_idx),
		.o_result_data(result_data), .o_ev(ev));
	cdc_result_status_regs uut (.i_clock(clock), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.i_result_wr(result_wr), .i_result_idx(result_idx), .i_result_data(result_data),
		.i_wdog_por(ev[0]), .i_config_por(ev[1]), .i_cause_clear(ev[2]), .i_cap_trigger(ev[3]),
		.i_dsp_active(ev[4]), .o_initial_reset(init_rst), .i_autoboot_busy(ev[5]),
		.i_res_conv_ready(ev[6]), .i_res_conv_busy(ev[7]), .i_cap_conv_active(ev[8]),
		.i_run_enable(ev[9]), .i_conv_start(ev[10]), .i_res_conv_error(ev[11]),
		.i_tdc_error(ev[12]), .i_overflow_error(ev[13]), .i_cap_port_fault(ev[20:14]),
		.o_irq(irq));
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(d, exp);
	endtask : rd
	function automatic logic [31:0] word_val(input int k);
		return (k == 7) ? 32'hffff_ffff : 32'h8765_4321 + 32'h0101_0101 * k;
	endfunction : word_val
	task automatic end_sim;
		$display("mismatches %0d, checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 35; i++) rd(4 * i, 32'h0);
		rd(32'ha4, 32'h0);
		for (int k = 0; k < 8; k++) fw.put_result(3'(k), word_val(k));
		for (int i = 0; i < 32; i++) begin
			v = word_val(i / 4);
			rd(4 * i, {24'h0, v[8 * (i % 4) +: 8]});
		end
		bus(32'h0, 1'b1, 32'h0);
		rd(32'h0, 32'h21);
		fw.step(LV | WDOG | CFG);
		fw.step(LV | TRIG | DSP);
		fw.step(LV);
		rd(32'h80, 32'hf7);
		bus(32'h80, 1'b1, 32'h0);
		rd(32'h80, 32'hf7);
		fw.step(CLR);
		fw.step(21'h0);
		rd(32'h80, 32'h0);
		fw.step(CSTART);
		fw.step(RERR | TDC | OVF | PF_ALL);
		fw.step(21'h0);
		rd(32'h84, 32'h0);
		rd(32'h88, 32'h0);
		fw.step(RBUSY | RERR);
		fw.step(CAPA | TDC);
		fw.step(CAPA | OVF);
		fw.step(21'h0);
		rd(32'h84, 32'hf);
		fw.step(CSTART);
		fw.step(CAPA | PF_REF);
		fw.step(21'h0);
		rd(32'h84, 32'h1);
		rd(32'h88, 32'h40);
		bus(32'ha0, 1'b0, 32'h0);
		bus(32'ha4, 1'b1, 32'h1);
		fw.put_result(3'h0, word_val(0));
		@(posedge clock);
		#1 chk({31'h0, irq}, 32'h0);
		fw.step(WDOG);
		fw.step(21'h0);
		@(posedge clock);
		#1 chk({31'h0, irq}, 32'h1);
		@(posedge clock);
		rd(32'ha0, 32'h81);
		#1 chk({31'h0, irq}, 32'h0);
		@(posedge clock);
		rd(32'hfc, 32'h0);
		end_sim();
	end
endmodule : tb_top
